// *** common/rrx_defines.svh ***
// register offsets, field positions, reset values and timing counts of the
// remote receiver front end; included by the package user files by bare name
`ifndef RRX_DEFINES_SVH
`define RRX_DEFINES_SVH

// byte addresses on the apb bus, one aligned word each
`define RRX_OFF_COND 8'h00
`define RRX_OFF_CTRL 8'h04
`define RRX_OFF_STAT 8'h08
`define RRX_OFF_MASK 8'h0C

// input conditioning word
`define RRX_COND_POL_BIT 7
`define RRX_COND_NC_LSB 0
`define RRX_COND_NC_W 4

// completion control word
`define RRX_CTRL_MAX_LSB 0
`define RRX_CTRL_LOW_LSB 8
`define RRX_CTRL_EN_BIT 16

// status and mask words share the two flag bits; the busy bit is in status only
`define RRX_STAT_MAX_BIT 0
`define RRX_STAT_LOW_BIT 1
`define RRX_STAT_BUSY_BIT 2

// reset values
`define RRX_RST_POL 1'h0
`define RRX_RST_NC 4'h0
`define RRX_RST_THR 8'h00
`define RRX_RST_EN 1'h0
`define RRX_RST_FLAGS 2'h0
`define RRX_RST_MASK 2'h0

// clock cycles per threshold tick
`define RRX_TICK_CYCLES 1

`endif

// *** common/rrx_pkg.sv ***
// types shared by the remote receiver front end
// assumes the defines header supplies all numeric constants
package rrx_pkg;

  // reception state, gray along idle -> receive -> idle
  typedef enum logic [0:0] {
    RRX_IDLE = 1'h0,
    RRX_RECV = 1'h1
  } rrx_state_t;

  // completion flags as held in status and mask
  typedef logic [1:0] rrx_flags_t;

endpackage : rrx_pkg

// *** rtl/rrx_noise_filter.sv ***
// glitch filter for the conditioned remote input
// assumes raw_i is already synchronised to clk_i
module rrx_noise_filter #(
  parameter int unsigned W = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] nc_i,
  input wire logic raw_i,
  output logic filt_o
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_filt;

  // a new level must persist nc_i consecutive cycles before it is passed on
  always_comb begin
    next_cnt = '0;
    next_filt = filt_o;
    if (nc_i == '0) begin
      next_filt = raw_i;
    end else if (raw_i != filt_o) begin
      if (cnt == nc_i - W'(1)) begin
        next_filt = raw_i;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end

  // a pulse shorter than the window drops the count back to zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt <= '0;
      filt_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      filt_o <= next_filt;
    end
  end

endmodule : rrx_noise_filter

// *** rtl/rrx_top.sv ***
// remote-control receiver front end: input sync, polarity, noise filter,
// end-of-reception detection, status/mask/interrupt and an apb slave
// assumes an apb master on clk_i and an asynchronous remote input pin
//
// Functional notes
// - bit 7 of the conditioning register inverts the remote input when set.
// - a noise field of zero or one passes the input unfiltered, any other value filters it.
// - the noise window is the field value times one sampling clock period.
// - with both completions enabled, the first one detected ends reception.
// - no falling edge within the max bit-cycle threshold is a max-cycle event.
// - a max-cycle event ends reception, raises the interrupt and sets its flag.
// - staying low longer than the low-width limit after a falling edge is an event.
// - a low-excess event ends reception and, unless a max-cycle event comes in the same cycle, raises the interrupt and sets its flag.
//
// Design decisions made here: the APB register port and the register offsets.
`include "rrx_defines.svh"

module rrx_top #(
  parameter int unsigned NC_W = `RRX_COND_NC_W,
  parameter int unsigned TICK_CYCLES = `RRX_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic remote_in_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic rx_active_o,
  output logic conditioned_o
);

  // tick divider width; kept at one bit even when every clock is a tick
  localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [8:0] CNT_MAX = 9'h1FF;

  // ---- register state
  logic input_polarity_invert;
  logic [NC_W-1:0] noise_cancel;
  logic [7:0] max_bit_cycle_threshold;
  logic [7:0] low_width_limit;
  logic rx_enable;
  rrx_pkg::rrx_flags_t flags;
  rrx_pkg::rrx_flags_t irq_mask;
  logic next_input_polarity_invert;
  logic [NC_W-1:0] next_noise_cancel;
  logic [7:0] next_max_bit_cycle_threshold;
  logic [7:0] next_low_width_limit;
  logic next_rx_enable;
  rrx_pkg::rrx_flags_t next_flags;
  rrx_pkg::rrx_flags_t next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  // ---- input path state
  logic sync1;
  logic sync2;
  logic sync3;
  logic level;
  logic next_level;
  logic cond_raw;
  logic next_cond_raw;
  logic filt;
  logic filt_d;

  // ---- completion state
  rrx_pkg::rrx_state_t state;
  rrx_pkg::rrx_state_t next_state;
  logic [TW-1:0] tick_cnt;
  logic [TW-1:0] next_tick_cnt;
  logic [8:0] bit_cnt;
  logic [8:0] next_bit_cnt;
  logic [8:0] low_cnt;
  logic [8:0] next_low_cnt;
  logic next_rx_active;

  // ---- helpers
  logic apb_done;
  logic wr;
  logic rd;
  logic tick;
  logic fall;
  logic max_hit;
  logic low_hit;
  rrx_pkg::rrx_flags_t evt;

  // writes and the status clear land only at the edge that completes a transfer
  assign apb_done = psel_i & penable_i & pready_o;
  assign wr = apb_done & pwrite_i;
  assign rd = apb_done & ~pwrite_i;
  assign tick = (tick_cnt == TICK_LAST);
  assign fall = filt_d & ~filt;

  // ---- input synchroniser: a change counts once stages two and three agree
  always_comb begin
    next_level = level;
    if (sync2 == sync3) begin
      next_level = sync3;
    end
    next_cond_raw = level ^ input_polarity_invert;
  end

  // the chain resets low; a resting high pin then rises, never taken as a start
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
      cond_raw <= 1'b0;
    end else begin
      sync1 <= remote_in_i;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
      cond_raw <= next_cond_raw;
    end
  end

  // glitch filter on the polarity-corrected level
  rrx_noise_filter #(
    .W(NC_W)
  ) u_filter (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .nc_i(noise_cancel),
    .raw_i(cond_raw),
    .filt_o(filt)
  );

  // ---- completion detection
  // counters are in ticks; they saturate so a stuck line cannot wrap back
  always_comb begin
    next_state = state;
    next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
    next_bit_cnt = bit_cnt;
    next_low_cnt = low_cnt;
    // limit of zero keeps that completion off
    max_hit = 1'b0;
    low_hit = 1'b0;
    evt = 2'h0;
    unique case (state)
      rrx_pkg::RRX_IDLE: begin
        next_bit_cnt = 9'h000;
        next_low_cnt = 9'h000;
        if (rx_enable && fall) begin
          next_state = rrx_pkg::RRX_RECV;
        end
      end
      rrx_pkg::RRX_RECV: begin
        max_hit = (max_bit_cycle_threshold != 8'h00) &&
                  (bit_cnt >= {1'b0, max_bit_cycle_threshold});
        low_hit = (low_width_limit != 8'h00) && !filt &&
                  (low_cnt > {1'b0, low_width_limit});
        if (fall) begin
          next_bit_cnt = 9'h000;
        end else if (tick && bit_cnt != CNT_MAX) begin
          next_bit_cnt = bit_cnt + 9'h001;
        end
        if (filt) begin
          next_low_cnt = 9'h000;
        end else if (tick && low_cnt != CNT_MAX) begin
          next_low_cnt = low_cnt + 9'h001;
        end
        // max-cycle wins a tie so exactly one cause is reported
        if (max_hit) begin
          evt[`RRX_STAT_MAX_BIT] = 1'b1;
          next_state = rrx_pkg::RRX_IDLE;
        end else if (low_hit) begin
          evt[`RRX_STAT_LOW_BIT] = 1'b1;
          next_state = rrx_pkg::RRX_IDLE;
        end else if (!rx_enable) begin
          next_state = rrx_pkg::RRX_IDLE;
        end
      end
    endcase
    next_rx_active = (next_state == rrx_pkg::RRX_RECV);
  end

  // a limit changed mid-reception counts from the next compare, so software
  // should set limits while rx enable is low
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= rrx_pkg::RRX_IDLE;
      tick_cnt <= '0;
      bit_cnt <= 9'h000;
      low_cnt <= 9'h000;
      filt_d <= 1'b0;
      rx_active_o <= 1'b0;
      conditioned_o <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      bit_cnt <= next_bit_cnt;
      low_cnt <= next_low_cnt;
      filt_d <= filt;
      rx_active_o <= next_rx_active;
      conditioned_o <= filt;
    end
  end

  // ---- apb register file, one wait state on every access
  always_comb begin
    next_input_polarity_invert = input_polarity_invert;
    next_noise_cancel = noise_cancel;
    next_max_bit_cycle_threshold = max_bit_cycle_threshold;
    next_low_width_limit = low_width_limit;
    next_rx_enable = rx_enable;
    next_irq_mask = irq_mask;
    next_flags = flags;
    next_pready = psel_i & penable_i & ~pready_o;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    // read data and error are staged for the cycle pready is high
    if (psel_i && penable_i && !pready_o) begin
      unique case (paddr_i)
        `RRX_OFF_COND: begin
          next_prdata[`RRX_COND_POL_BIT] = input_polarity_invert;
          next_prdata[`RRX_COND_NC_LSB +: NC_W] = noise_cancel;
        end
        `RRX_OFF_CTRL: begin
          next_prdata[`RRX_CTRL_MAX_LSB +: 8] = max_bit_cycle_threshold;
          next_prdata[`RRX_CTRL_LOW_LSB +: 8] = low_width_limit;
          next_prdata[`RRX_CTRL_EN_BIT] = rx_enable;
        end
        `RRX_OFF_STAT: begin
          next_prdata[1:0] = flags;
          next_prdata[`RRX_STAT_BUSY_BIT] = rx_active_o;
        end
        `RRX_OFF_MASK: begin
          next_prdata[1:0] = irq_mask;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr && paddr_i == `RRX_OFF_COND && pstrb_i[0]) begin
      next_input_polarity_invert = pwdata_i[`RRX_COND_POL_BIT];
      next_noise_cancel = pwdata_i[`RRX_COND_NC_LSB +: NC_W];
    end
    if (wr && paddr_i == `RRX_OFF_CTRL) begin
      if (pstrb_i[0]) begin
        next_max_bit_cycle_threshold = pwdata_i[`RRX_CTRL_MAX_LSB +: 8];
      end
      if (pstrb_i[1]) begin
        next_low_width_limit = pwdata_i[`RRX_CTRL_LOW_LSB +: 8];
      end
      if (pstrb_i[2]) begin
        next_rx_enable = pwdata_i[`RRX_CTRL_EN_BIT];
      end
    end
    if (wr && paddr_i == `RRX_OFF_MASK && pstrb_i[0]) begin
      next_irq_mask = pwdata_i[1:0];
    end
    // read clears the status; a same-cycle event still lands
    if (rd && paddr_i == `RRX_OFF_STAT) begin
      next_flags = 2'h0;
    end
    next_flags = next_flags | evt;
    next_irq = |(next_flags & next_irq_mask);
  end

  // every bus output is a flop so the master samples settled values
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      input_polarity_invert <= `RRX_RST_POL;
      noise_cancel <= `RRX_RST_NC;
      max_bit_cycle_threshold <= `RRX_RST_THR;
      low_width_limit <= `RRX_RST_THR;
      rx_enable <= `RRX_RST_EN;
      irq_mask <= `RRX_RST_MASK;
      flags <= `RRX_RST_FLAGS;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      input_polarity_invert <= next_input_polarity_invert;
      noise_cancel <= next_noise_cancel;
      max_bit_cycle_threshold <= next_max_bit_cycle_threshold;
      low_width_limit <= next_low_width_limit;
      rx_enable <= next_rx_enable;
      irq_mask <= next_irq_mask;
      flags <= next_flags;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      irq_o <= next_irq;
    end
  end

endmodule : rrx_top

// *** verif/rrx_top_properties.sv ***
// port checker of the remote receiver front end
// assumes binding into rrx_top; one clock, synchronous active-low reset
`include "rrx_defines.svh"
module rrx_top_properties #(
  parameter int unsigned NC_W = 4,
  parameter int unsigned TICK_CYCLES = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic irq_o,
  input wire logic rx_active_o,
  input wire logic conditioned_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] thr, lim;
  logic [1:0] msk;
  logic en, wr_ctrl, wr_mask;
  logic [9:0] bcnt, lcnt;
  // shadows follow writes at the edge that completes them
  assign wr_ctrl = pready_o && pwrite_i && paddr_i == `RRX_OFF_CTRL;
  assign wr_mask = pready_o && pwrite_i && paddr_i == `RRX_OFF_MASK;
  // counters are loose by a few cycles: sync and filter delay shift the edges
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      thr <= 8'h00;
      lim <= 8'h00;
      msk <= 2'h0;
      en <= 1'h0;
      bcnt <= 10'h000;
      lcnt <= 10'h000;
    end else begin
      if (wr_ctrl && pstrb_i[0]) thr <= pwdata_i[7:0];
      if (wr_ctrl && pstrb_i[1]) lim <= pwdata_i[15:8];
      if (wr_ctrl && pstrb_i[2]) en <= pwdata_i[16];
      if (wr_mask && pstrb_i[0]) msk <= pwdata_i[1:0];
      bcnt <= (!rx_active_o || $fell(conditioned_o)) ? 10'h000 : bcnt + 10'h001;
      lcnt <= (!rx_active_o || conditioned_o) ? 10'h000 : lcnt + 10'h001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready after one wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_idle_quiet: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read data or error outside answer");
  a_err_map: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h0C || paddr_i[1:0] != 2'h0))
    else $error("error flag does not match address");
  a_start_edge: assert property ($rose(rx_active_o) |-> en && (!conditioned_o || !$past(conditioned_o)))
    else $error("reception started without falling edge");
  a_max_bound: assert property (thr != 8'h00 |-> bcnt <= thr * TICK_CYCLES + 10'h006)
    else $error("reception outlived bit cycle threshold");
  a_low_bound: assert property (lim != 8'h00 |-> lcnt <= lim * TICK_CYCLES + 10'h006)
    else $error("low level outlived width limit");
  a_end_irq: assert property ($fell(rx_active_o) && en && $past(en) && msk == 2'h3 |-> ##[0:1] irq_o)
    else $error("completion without interrupt");
  a_irq_clear: assert property (pready_o && !pwrite_i && paddr_i == `RRX_OFF_STAT && !rx_active_o |-> ##[1:2] !irq_o)
    else $error("interrupt stayed after status read");
  cover property ($fell(rx_active_o));
  cover property (pready_o && pslverr_o);
  cover property ($rose(irq_o));
endmodule : rrx_top_properties

bind rrx_top rrx_top_properties #(.NC_W(NC_W), .TICK_CYCLES(TICK_CYCLES)) rrx_top_properties_inst (.*);

// *** verif/rrx_remote_src.sv ***
// model of the remote-control demodulator output feeding the pin
// assumes calls start just after a rising clock edge
module rrx_remote_src (
  input wire logic clk_i,
  output logic remote_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // the line rests high between bursts, like a demodulator output
  initial remote_o = 1'h1;
  // one low burst of n cycles, then back to rest
  task burst_low(input int n);
    remote_o <= 1'h0;
    repeat (n) @(posedge clk_i);
    remote_o <= 1'h1;
  endtask : burst_low
endmodule : rrx_remote_src

// *** verif/rrx_top_tb.sv ***
// self-checking bench of the remote receiver front end
// assumes the sender model on the pin and the checker bound into rrx_top
`include "rrx_defines.svh"
`define CHK(a, e) begin total_checks++; \
  if ((a) !== (e)) begin fails++; $display("unexpected %0t value %h", $time, a); end end
module rrx_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o, rd;
  logic remote_in_i, pready_o, pslverr_o, irq_o, rx_active_o, conditioned_o, err, seen;
  int fails = 0;
  int total_checks = 0;
  int t, l, n;
  // 10 mhz sampling clock
  always #50 clk_i = ~clk_i;
  rrx_top rrx_top_inst (.*);
  rrx_remote_src rrx_remote_src_inst (.clk_i(clk_i), .remote_o(remote_in_i));
  // first finishing event wins; a tie reports the bit cycle
  function logic [31:0] stat_exp(input int t, input int l, input int n);
    return (l != 0 && n > l + 1 && (t == 0 || l + 1 < t)) ? 32'h2 : 32'h1;
  endfunction : stat_exp
  // one transfer held until pready is seen high at a rising edge, answer taken
  // there; an idle cycle after it keeps drivers from double assignment
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'h1);
    `CHK(k, 2)
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask : apb
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(69));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'h1;
    @(posedge clk_i);
    // reset values, then one unmapped word
    for (int a = 0; a < 20; a += 4) begin
      apb(1'h0, 8'(a), 32'h0);
      `CHK(rd, 32'h0)
      `CHK(err, (a == 16))
    end
    // only polarity and noise fields hold
    repeat (4) begin
      t = $urandom;
      apb(1'h1, `RRX_OFF_COND, 32'(t));
      apb(1'h0, `RRX_OFF_COND, 32'h0);
      `CHK(rd, 32'(t) & 32'h0000008F)
    end
    // lane 0 strobe off: the conditioning byte keeps its value
    pstrb_i <= 4'hE;
    apb(1'h1, `RRX_OFF_COND, ~32'(t));
    pstrb_i <= 4'hF;
    apb(1'h0, `RRX_OFF_COND, 32'h0);
    `CHK(rd, 32'(t) & 32'h0000008F)
    // resting high pin seen as is, then inverted
    for (int p = 0; p < 2; p++) begin
      apb(1'h1, `RRX_OFF_COND, 32'(p) << 7);
      repeat (10) @(posedge clk_i);
      `CHK(conditioned_o, ~p[0])
    end
    // a burst one short of the window vanishes, a full one passes
    for (int k = 0; k < 6; k++) begin
      l = (k > 3) ? 15 : 2 + $urandom % 14;
      apb(1'h1, `RRX_OFF_COND, 32'(l));
      // the polarity flip before the first pass needs a full window to settle
      repeat (20) @(posedge clk_i);
      rrx_remote_src_inst.burst_low(l - 1 + k % 2);
      seen = 1'h1;
      repeat (l + 12) @(posedge clk_i) seen &= conditioned_o;
      `CHK(seen, (k % 2 == 0))
    end
    apb(1'h1, `RRX_OFF_COND, 32'h0);
    apb(1'h1, `RRX_OFF_MASK, 32'h3);
    // bit cycle only, low width only, both armed with low width first
    for (int c = 0; c < 3; c++) begin
      t = (c == 1) ? 0 : (c == 2) ? 60 : 20 + $urandom % 21;
      l = (c == 0) ? 0 : 4 + $urandom % 8;
      n = (c == 0) ? 2 : 40;
      apb(1'h1, `RRX_OFF_CTRL, 32'(32'h10000 | l << 8 | t));
      fork
        rrx_remote_src_inst.burst_low(n);
      join_none
      // a reception that never starts or ends is left to the watchdog
      while (rx_active_o !== 1'h1) @(posedge clk_i);
      while (rx_active_o !== 1'h0) @(posedge clk_i);
      repeat (45) @(posedge clk_i);
      `CHK(irq_o, 1'h1)
      apb(1'h0, `RRX_OFF_STAT, 32'h0);
      `CHK(rd, stat_exp(t, l, n))
      `CHK(irq_o, 1'h0)
    end
    test_done();
  end
endmodule : rrx_top_tb
